// file: rtl/edge_filter.sv
// Input edge filter channel with glitch detection and AHB-Lite registers
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`include "edge_filter_regs.svh"

module edge_filter
  import edge_filter_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        filter_in,
  output logic             filter_out,
  output logic             glitch_detect_event,
  output logic             external_capture_input,
  output logic             irq
);

  // Bus side state
  bus_req_type             req_q;
  logic                    wr_pend_q;
  logic [31:0]             rdata_q;
  ctrl_type                ctrl_q;
  logic [`EF_THR_W-1:0]    rise_thr_q;
  logic [`EF_THR_W-1:0]    fall_thr_q;
  logic [`EF_EVT_W-1:0]    status_q;
  logic [`EF_EVT_W-1:0]    mask_q;
  logic                    irq_q;

  // Filter state
  logic                    sync1_q;
  logic                    sync2_q;
  logic                    in_prev_q;
  logic                    out_q;
  filt_state_type          state_q;
  logic [`EF_CNT_W-1:0]    cnt_q;
  logic [`EF_DIV_W-1:0]    div_q;
  logic                    glitch_q;
  logic                    edge_evt_q;
  logic                    capture_q;

  logic                    addr_phase;
  logic                    wr_en;
  logic [`EF_DIV_W-1:0]    div_mask;
  logic                    tick;
  logic                    rising;
  logic                    mode_cur;
  logic [`EF_THR_W-1:0]    thr_cur;
  logic [`EF_CNT_W-1:0]    cnt_inc;
  logic                    reached;
  logic                    in_edge;
  logic                    glitch_now;
  logic                    accept_now;
  logic [`EF_EVT_W-1:0]    evt_set;
  logic [`EF_EVT_W-1:0]    evt_clr;
  logic [31:0]             rd_mux;

  // Address phase taken only when the bus is ready
  assign addr_phase = hsel && hready &&
                      (htrans == `EF_HTRANS_NONSEQ || htrans == `EF_HTRANS_SEQ);
  assign wr_en      = wr_pend_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q     <= '0;
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase) begin
        req_q.write <= hwrite;
        req_q.addr  <= {haddr[`EF_ADDR_W-1:`EF_ADDR_LSB], 2'b00};
      end
    end
  end

  // Read data sampled in address phase so hrdata leaves a flip-flop
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case ({haddr[`EF_ADDR_W-1:`EF_ADDR_LSB], 2'b00})
      `EF_OFS_CTRL:     rd_mux[`EF_CTRL_W-1:0] = ctrl_q;
      `EF_OFS_RISE_THR: rd_mux[`EF_THR_W-1:0]  = rise_thr_q;
      `EF_OFS_FALL_THR: rd_mux[`EF_THR_W-1:0]  = fall_thr_q;
      `EF_OFS_STATUS:   rd_mux[`EF_EVT_W-1:0]  = status_q;
      `EF_OFS_MASK:     rd_mux[`EF_EVT_W-1:0]  = mask_q;
      `EF_OFS_STATE: begin
        rd_mux[`EF_STATE_OUT]  = out_q;
        rd_mux[`EF_STATE_IN]   = sync2_q;
        rd_mux[`EF_STATE_BUSY] = (state_q != ST_IDLE);
        rd_mux[`EF_STATE_CNT_LSB +: `EF_CNT_W] = cnt_q;
      end
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      rdata_q <= rd_mux;
    end
  end

  // Control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= ctrl_type'(`EF_CTRL_RST);
    end else if (wr_en && req_q.addr == `EF_OFS_CTRL) begin
      ctrl_q <= ctrl_type'(hwdata[`EF_CTRL_W-1:0]);
    end
  end

  // Rising threshold, in divided clock ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_thr_q <= `EF_THR_RST;
    end else if (wr_en && req_q.addr == `EF_OFS_RISE_THR) begin
      rise_thr_q <= hwdata[`EF_THR_W-1:0];
    end
  end

  // Falling threshold, in divided clock ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_thr_q <= `EF_THR_RST;
    end else if (wr_en && req_q.addr == `EF_OFS_FALL_THR) begin
      fall_thr_q <= hwdata[`EF_THR_W-1:0];
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= `EF_EVT_RST;
    end else if (wr_en && req_q.addr == `EF_OFS_MASK) begin
      mask_q <= hwdata[`EF_EVT_W-1:0];
    end
  end

  // Pin synchroniser; only the second stage feeds logic
  // Reset low matches an idle pin, so no false edge follows reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q   <= 1'b0;
      sync2_q   <= 1'b0;
      in_prev_q <= 1'b0;
    end else begin
      sync1_q   <= filter_in;
      sync2_q   <= sync1_q;
      in_prev_q <= sync2_q;
    end
  end

  // Divided clock tick: one hclk cycle in every 2^clk_sel
  assign div_mask = `EF_DIV_W'((`EF_DIV_W'(1) << ctrl_q.clk_sel) - `EF_DIV_W'(1));
  assign tick     = (div_q & div_mask) == '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= '0;
    end else begin
      div_q <= `EF_DIV_W'(div_q + `EF_DIV_W'(1));
    end
  end

  // Edge direction picks mode and threshold per edge
  // A pending edge heads away from the output; a held one has reached it
  assign rising   = (state_q == ST_HOLD) ? out_q : !out_q;
  assign mode_cur = rising ? ctrl_q.rise_mode : ctrl_q.fall_mode;
  assign thr_cur  = rising ? rise_thr_q : fall_thr_q;
  assign cnt_inc  = tick ? `EF_CNT_W'(cnt_q + `EF_CNT_W'(1)) : cnt_q;
  assign reached  = cnt_inc >= thr_cur;
  assign in_edge  = sync2_q != in_prev_q;

  // Only the input edge itself counts, so a lasting glitch is one pulse
  always_comb begin
    glitch_now = 1'b0;
    accept_now = 1'b0;
    if (ctrl_q.enable) begin
      unique case (state_q)
        ST_IDLE: accept_now = (sync2_q != out_q) && !mode_cur;
        ST_PEND: begin
          glitch_now = in_edge && (sync2_q == out_q);
          accept_now = !glitch_now && reached;
        end
        ST_HOLD: glitch_now = in_edge;
        default: glitch_now = 1'b0;
      endcase
    end
  end

  // Filter sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      out_q   <= 1'b0;
    end else if (!ctrl_q.enable) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      out_q   <= sync2_q;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (sync2_q != out_q) begin
            if (!mode_cur) begin
              out_q <= sync2_q;
              // Zero threshold needs no acceptance interval
              state_q <= (thr_cur == '0) ? ST_IDLE : ST_HOLD;
            end else begin
              state_q <= ST_PEND;
            end
          end
        end
        ST_PEND: begin
          // Glitch checked first, so it wins at the threshold cycle
          if (glitch_now) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
          end else if (reached) begin
            out_q   <= sync2_q;
            state_q <= ST_IDLE;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_inc;
          end
        end
        ST_HOLD: begin
          // Acceptance interval; input edges here are glitches, output holds
          if (reached) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_inc;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  // Glitch pulse; edge based, so a lasting glitch gives one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      glitch_q <= 1'b0;
    end else begin
      glitch_q <= glitch_now;
    end
  end

  // Accepted edge pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_evt_q <= 1'b0;
    end else begin
      edge_evt_q <= accept_now;
    end
  end

  // Capture pulse only while the glitch is the selected source
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_q <= 1'b0;
    end else begin
      capture_q <= glitch_now && ctrl_q.ext_glitch;
    end
  end

  // Sticky status, write one to clear, set wins over clear
  always_comb begin
    evt_set = '0;
    evt_set[`EF_EVT_GLITCH] = glitch_q;
    evt_set[`EF_EVT_EDGE]   = edge_evt_q;
    evt_clr = '0;
    if (wr_en && req_q.addr == `EF_OFS_STATUS) begin
      evt_clr = hwdata[`EF_EVT_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= `EF_EVT_RST;
    end else begin
      // Pulse event cannot re-set after clear
      status_q <= (status_q & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((status_q & ~evt_clr) | evt_set) & mask_q);
    end
  end

  // Zero wait states, ready from the first edge after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // Response is always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  assign hrdata                 = rdata_q;
  assign filter_out             = out_q;
  assign glitch_detect_event    = glitch_q;
  assign external_capture_input = capture_q;
  assign irq                    = irq_q;

endmodule : edge_filter

// file: rtl/edge_filter_pkg.sv
// Types shared by the edge filter design
package edge_filter_pkg;

  typedef struct packed {
    logic       ext_glitch;
    logic [2:0] clk_sel;
    logic       fall_mode;
    logic       rise_mode;
    logic       spare;
    logic       enable;
  } ctrl_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_PEND = 3'h2,
    ST_HOLD = 3'h4
  } filt_state_type;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
  } bus_req_type;

endpackage : edge_filter_pkg

// file: rtl/edge_filter_regs.svh
// Register map, field positions and reset values of the edge filter
`ifndef EDGE_FILTER_REGS_SVH
`define EDGE_FILTER_REGS_SVH

`define EF_OFS_CTRL       8'h00
`define EF_OFS_RISE_THR   8'h04
`define EF_OFS_FALL_THR   8'h08
`define EF_OFS_STATUS     8'h0c
`define EF_OFS_MASK       8'h10
`define EF_OFS_STATE      8'h14

`define EF_CTRL_W         8
`define EF_CTRL_RST       8'h00
`define EF_THR_W          16
`define EF_THR_RST        16'h0000
`define EF_CNT_W          16

`define EF_EVT_W          2
`define EF_EVT_GLITCH     0
`define EF_EVT_EDGE       1
`define EF_EVT_RST        2'h0

`define EF_STATE_OUT      0
`define EF_STATE_IN       1
`define EF_STATE_BUSY     2
`define EF_STATE_CNT_LSB  16

`define EF_DIV_W          16
`define EF_SEL_W          3

`define EF_HTRANS_NONSEQ  2'h2
`define EF_HTRANS_SEQ     2'h3
`define EF_ADDR_LSB       2
`define EF_ADDR_W         8

`endif

// file: test/edge_filter_properties.sv
// Port checks of the edge filter channel
`timescale 1ns/1ns
`include "edge_filter_regs.svh"
module edge_filter_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        filter_in,
  input wire logic        filter_out,
  input wire logic        glitch_detect_event,
  input wire logic        external_capture_input,
  input wire logic        irq
);
  logic       wr_q;
  logic [7:0] wa_q;
  logic [7:0] ctrl_q;
  logic       mask_q;
  logic       rz_q;
  logic       fz_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Shadow of config writes; aligned words only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      wa_q   <= 8'h0;
      ctrl_q <= 8'h0;
      mask_q <= 1'b0;
      rz_q   <= 1'b1;
      fz_q   <= 1'b1;
    end else if (hready) begin
      wr_q <= hsel && htrans[1] && hwrite;
      wa_q <= {haddr[7:2], 2'b00};
      if (wr_q && wa_q == `EF_OFS_CTRL) ctrl_q <= hwdata[7:0];
      if (wr_q && wa_q == `EF_OFS_MASK) mask_q <= hwdata[`EF_EVT_GLITCH];
      if (wr_q && wa_q == `EF_OFS_RISE_THR) rz_q <= hwdata[15:0] == 16'h0;
      if (wr_q && wa_q == `EF_OFS_FALL_THR) fz_q <= hwdata[15:0] == 16'h0;
    end
  end
  property p_single; glitch_detect_event |=> !glitch_detect_event; endproperty
  a_single: assert property (p_single) else $error("long event");
  // Event only follows a pin change; a lasting level gives none
  property p_cause; glitch_detect_event |-> $past(filter_in, 2) != $past(filter_in, 3)
    || $past(filter_in, 3) != $past(filter_in, 4) || $past(filter_in, 4) != $past(filter_in, 5);
  endproperty
  a_cause: assert property (p_cause) else $error("event without edge");
  property p_ext; external_capture_input == (glitch_detect_event && ctrl_q[7]); endproperty
  a_ext: assert property (p_ext) else $error("capture mismatch");
  property p_irq; glitch_detect_event && mask_q |-> ##2 irq; endproperty
  a_irq: assert property (p_irq) else $error("no irq");
  property p_off; !ctrl_q[0] && !$past(ctrl_q[0], 4) |-> !glitch_detect_event; endproperty
  a_off: assert property (p_off) else $error("event while off");
  property p_track; !ctrl_q[0] && !$past(ctrl_q[0], 4) |-> filter_out == $past(filter_in, 3);
  endproperty
  a_track: assert property (p_track) else $error("no tracking");
  property p_imm_r; ctrl_q[0] && ctrl_q[3:2] == 2'b00 && rz_q && fz_q && $rose(filter_in)
    |-> ##[1:5] filter_out; endproperty
  a_imm_r: assert property (p_imm_r) else $error("rise late");
  property p_imm_f; ctrl_q[0] && ctrl_q[3:2] == 2'b00 && rz_q && fz_q && $fell(filter_in)
    |-> ##[1:5] !filter_out; endproperty
  a_imm_f: assert property (p_imm_f) else $error("fall late");
endmodule : edge_filter_checker
bind edge_filter edge_filter_checker chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .filter_in, .filter_out, .glitch_detect_event, .external_capture_input,
  .irq);

// file: test/tb_timer_input_edge_filter_glitch.sv
// Self-checking bench of the edge filter channel
`timescale 1ns/1ns
`include "edge_filter_regs.svh"
module tb_timer_input_edge_filter_glitch;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        filter_in = 1'b0;
  logic        rd_ph = 1'b0;
  logic        hreadyout, hresp, filter_out, glitch_detect_event, external_capture_input, irq;
  logic [31:0] hrdata;
  logic [31:0] exp_q[$], msk_q[$];
  int          error_cnt = 0, tests_run = 0, ev_cnt = 0, ext_cnt = 0, up_cnt = 0, e0;
  always #5 hclk = ~hclk;
  edge_filter uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .filter_in, .filter_out,
    .glitch_detect_event, .external_capture_input, .irq);
  task automatic end_of_test;
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t read %h want %h", $time, got, exp);
    end
  endtask : cmp_rd
  task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t value %h want %h", $time, got, exp);
    end
  endtask : cmp_v
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  // Bounded wait for hready; a hang counts as a mismatch
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 50) error_cnt++;
      if (n > 50) end_of_test();
    end while (hreadyout !== 1'b1);
  endtask : rdy
  // Single word transfer; for reads d is the expected value under mask m
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, m);
    if (!w) msk_q.push_back(m);
    if (!w) exp_q.push_back(d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= `EF_HTRANS_NONSEQ;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    rdy();
    rd_ph <= 1'b0;
    cyc(1);
  endtask : bus
  task automatic pulse(input int wd);
    filter_in <= 1'b1;
    cyc(wd);
    filter_in <= 1'b0;
    cyc(16);
  endtask : pulse
  always @(posedge hclk) begin
    if (glitch_detect_event === 1'b1) ev_cnt++;
    if (external_capture_input === 1'b1) ext_cnt++;
    if (rd_ph && hreadyout === 1'b1) cmp_rd(hrdata & msk_q.pop_front(), exp_q.pop_front());
    if (rd_ph && hreadyout === 1'b1) cmp_v(hresp, 0);
  end
  always @(posedge filter_out) up_cnt++;
  initial begin
    void'($urandom(32'h6b3d));
    cyc(8);
    hresetn <= 1'b1;
    cyc(2);
    for (int a = 0; a < 32; a += 4) bus(1'b0, a[7:0], 32'h0, 32'hffffffff);
    bus(1'b1, 8'h20, 32'hffffffff, 32'h0);
    bus(1'b0, 8'h20, 32'h0, 32'hffffffff);
    $display("reset values done");
    bus(1'b1, `EF_OFS_RISE_THR, 32'd20, 32'h0);
    bus(1'b1, `EF_OFS_CTRL, 32'h8d, 32'h0);
    for (int i = 0; i < 4; i++) pulse(1 + $urandom % 4);
    cmp_v(ev_cnt, 4);
    cmp_v(ext_cnt, 4);
    cmp_v(irq, 0);
    bus(1'b0, `EF_OFS_STATUS, 32'h1, 32'h3);
    bus(1'b1, `EF_OFS_MASK, 32'h1, 32'h0);
    cyc(2);
    cmp_v(irq, 1);
    bus(1'b1, `EF_OFS_STATUS, 32'h1, 32'h0);
    cyc(4);
    cmp_v(irq, 0);
    $display("glitch events done");
    bus(1'b1, `EF_OFS_RISE_THR, 32'd5, 32'h0);
    bus(1'b1, `EF_OFS_FALL_THR, 32'd5, 32'h0);
    bus(1'b1, `EF_OFS_CTRL, 32'h0d, 32'h0);
    // Width sweep crosses the threshold; each pulse is either glitch or accept
    for (int i = 1; i < 11; i++) begin
      e0 = ev_cnt + up_cnt;
      pulse(i);
      cmp_v(ev_cnt + up_cnt - e0, 1);
    end
    cmp_v(ext_cnt, 4);
    bus(1'b0, `EF_OFS_STATUS, 32'h3, 32'h3);
    bus(1'b1, `EF_OFS_RISE_THR, 32'd3, 32'h0);
    bus(1'b1, `EF_OFS_CTRL, 32'h2d, 32'h0);
    filter_in <= 1'b1;
    cyc(8);
    cmp_v(filter_out, 0);
    cyc(12);
    cmp_v(filter_out, 1);
    filter_in <= 1'b0;
    cyc(40);
    $display("threshold timing done");
    bus(1'b1, `EF_OFS_RISE_THR, 32'h0, 32'h0);
    bus(1'b1, `EF_OFS_FALL_THR, 32'h0, 32'h0);
    bus(1'b1, `EF_OFS_CTRL, 32'h01, 32'h0);
    for (int i = 0; i < 4; i++) begin
      filter_in <= ~filter_in;
      cyc(5 + $urandom % 3);
      cmp_v(filter_out, filter_in);
    end
    bus(1'b0, `EF_OFS_STATE, 32'h0, 32'hffff0000);
    bus(1'b1, `EF_OFS_FALL_THR, 32'd30, 32'h0);
    bus(1'b1, `EF_OFS_CTRL, 32'h09, 32'h0);
    filter_in <= 1'b1;
    cyc(6);
    cmp_v(filter_out, 1);
    filter_in <= 1'b0;
    cyc(6);
    cmp_v(filter_out, 1);
    cyc(40);
    $display("immediate mode done");
    // Lasting glitch in the hold window, flags cleared while it persists
    bus(1'b1, `EF_OFS_RISE_THR, 32'd20, 32'h0);
    bus(1'b1, `EF_OFS_STATUS, 32'h3, 32'h0);
    e0 = ev_cnt;
    filter_in <= 1'b1;
    cyc(4);
    filter_in <= 1'b0;
    cyc(6);
    cmp_v(irq, 1);
    bus(1'b1, `EF_OFS_STATUS, 32'h3, 32'h0);
    cyc(4);
    cmp_v(irq, 0);
    cmp_v(ev_cnt - e0, 1);
    $display("clear during glitch done");
    bus(1'b1, `EF_OFS_CTRL, 32'h00, 32'h0);
    e0 = ev_cnt;
    for (int i = 0; i < 2; i++) begin
      filter_in <= 1'b1;
      cyc(4);
      cmp_v(filter_out, 1);
      filter_in <= 1'b0;
      cyc(4);
      cmp_v(filter_out, 0);
    end
    pulse(1);
    cmp_v(ev_cnt - e0, 0);
    $display("disabled tracking done");
    end_of_test();
  end
endmodule : tb_timer_input_edge_filter_glitch
